// File: rtc_event_pkg.sv
// package: register map, field positions and timing constants for the
// alarm, watchdog and countdown timer logic
// assumes a 200 MHz system clock that stands in for the oscillator chain
package rtc_event_pkg;
    localparam logic [7:0] WATCHDOG_TIMEOUT_ADDR  = 8'h09;
    localparam logic [7:0] ALARM1_BASE_ADDR       = 8'h0a;
    localparam logic [7:0] EVENT_FLAGS_ADDR       = 8'h0f;
    localparam logic [7:0] COUNTDOWN_VALUE_ADDR   = 8'h10;
    localparam logic [7:0] COUNTDOWN_CONTROL_ADDR = 8'h11;
    localparam logic [7:0] ALARM_CONFIG_ADDR      = 8'h13;
    localparam logic [7:0] ALARM2_BASE_ADDR       = 8'h14;
    localparam int         ALARM_BYTES            = 5;

    // flags register bit positions
    localparam int FLAG_WATCHDOG  = 7;
    localparam int FLAG_ALARM1    = 6;
    localparam int FLAG_ALARM2    = 5;
    localparam int FLAG_COUNTDOWN = 3;
    // countdown control bit positions
    localparam int CTRL_ENABLE    = 7;
    localparam int CTRL_PULSE     = 6;
    localparam int CTRL_IRQ_EN    = 5;
    localparam int CTRL_SEL_HI    = 1;
    localparam int CTRL_SEL_LO    = 0;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'he3;
    localparam int CFG_ALARM2_EN  = 1;
    localparam logic [7:0] WATCHDOG_LOW_MASK = 8'h7f;

    // repeat codes
    localparam logic [4:0] RPT_SECOND = 5'h1f;
    localparam logic [4:0] RPT_MINUTE = 5'h1e;
    localparam logic [4:0] RPT_HOUR   = 5'h1c;
    localparam logic [4:0] RPT_DAY    = 5'h0c;
    localparam logic [4:0] RPT_MONTH  = 5'h10;
    localparam logic [4:0] RPT_YEAR   = 5'h00;

    // timing
    localparam longint CLK_HZ      = 200000000;
    localparam longint TICK_HZ     = 8192;
    localparam int     TICK_CYCLES = int'(CLK_HZ / TICK_HZ);
    // counts of 8192 Hz ticks
    localparam logic [18:0] TICKS_4096HZ  = 19'h00002;
    localparam logic [18:0] TICKS_64HZ    = 19'h00080;
    localparam logic [18:0] TICKS_1HZ     = 19'h02000;
    localparam logic [18:0] TICKS_60S     = 19'h78000;
    localparam logic [18:0] TICKS_64TH    = 19'h00080;
    localparam logic [15:0] WD_16TH_TICKS = 16'h0200;
    localparam logic [15:0] WD_4TH_TICKS  = 16'h0800;
    localparam logic [15:0] WD_1S_TICKS   = 16'h2000;
    localparam logic [15:0] WD_4S_TICKS   = 16'h8000;

    typedef enum logic [1:0] {SEL_4096, SEL_64, SEL_1, SEL_60S} source_sel_t;
endpackage : rtc_event_pkg

// File: alarm_store_if.sv
// interface: register write path and readback between the top and the alarm store
// assumes one clock domain
`timescale 1ns/1ps
`default_nettype none
interface alarm_store_if;
    logic       wrEn;
    logic [3:0] wrIdx;
    logic [7:0] wrData;
    logic [3:0] rdIdx;
    logic [7:0] rdData;
    logic [39:0] alarm1;
    logic [39:0] alarm2;
    modport host  (output wrEn, output wrIdx, output wrData, output rdIdx,
                   input rdData, input alarm1, input alarm2);
    modport store (input wrEn, input wrIdx, input wrData, input rdIdx,
                   output rdData, output alarm1, output alarm2);
endinterface : alarm_store_if
`default_nettype wire

// File: alarm_store.sv
// alarm store: ten setting bytes, two alarms of five bytes each
// assumes indices 0..4 for the first alarm, 5..9 for the second
`timescale 1ns/1ps
`default_nettype none
module alarm_store (
    input  wire logic    ref_clk,
    input  wire logic    nrst,
    alarm_store_if.store bus
);
    import rtc_event_pkg::*;
    logic [7:0] mem [0:9];
    logic [7:0] rdData;
    assign bus.rdData = rdData;
    assign bus.alarm1 = {mem[4], mem[3], mem[2], mem[1], mem[0]};
    assign bus.alarm2 = {mem[9], mem[8], mem[7], mem[6], mem[5]};
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 10; i++)
                mem[i] <= 8'h00;
            rdData <= 8'h00;
        end
        else
        begin
            if (bus.wrEn && bus.wrIdx < 4'ha)
                mem[bus.wrIdx] <= bus.wrData;
            rdData <= (bus.rdIdx < 4'ha) ? mem[bus.rdIdx] : 8'h00;
        end
    end
endmodule : alarm_store
`default_nettype wire

// File: tick_divider.sv
// divider: one-cycle 8192 Hz enable pulse from the system clock
// assumes one clock only
`timescale 1ns/1ps
`default_nettype none
module tick_divider (
    input  wire logic ref_clk,
    input  wire logic nrst,
    output logic      tick
);
    import rtc_event_pkg::*;
    localparam logic [15:0] LAST = 16'(TICK_CYCLES - 1);
    logic [15:0] count;
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            count <= 16'h0000;
            tick  <= 1'b0;
        end
        else
        begin
            tick  <= (count == LAST);
            count <= (count == LAST) ? 16'h0000 : count + 16'h0001;
        end
    end
endmodule : tick_divider
`default_nettype wire

// File: alarm_watchdog_countdown_timer.sv
// top: alarms, watchdog and countdown timer with a shared interrupt pin
// assumes register accesses arrive as one-cycle strobes from the serial port
// Function
// - two alarm setting blocks, five bytes each, configured independently
// - five repeat bits pick second/minute/hour/day/month/year matching
// - a matching alarm sets its flag
// - first alarm drives the interrupt when its enable is set
// - pointer resting on flags address holds off alarm flag setting
// - reading flags clears alarm flags and, outside backup mode, releases alarm interrupt
// - backup enable lets alarm interrupt assert in backup mode, held until a flags read after backup ends
// - second alarm enable makes the upper bytes an alarm, off at reset
// - second alarm only sets its flag, never the interrupt
// - watchdog timeout is multiplier times resolution
// - watchdog expiry sets its flag and interrupt
// - any watchdog write restarts the timeout
// - writing low seven watchdog bits releases interrupt; zero disables
// - flags read clears watchdog flag, leaves its interrupt; reset disables
// - timer counts down to one, reloads and sets its flag
// - value writes set reload, and the count too only while it is zero; reads return live count
// - timer stops when disabled or reload is zero, resumes on enable
// - level mode holds interrupt while flag set and enabled
// - clearing enable releases output; re-enable reasserts at once
// - pulse mode: low one source cycle per reload at 4096/64 Hz, 1/64 s at 1 and 1/60 Hz, independent of flag
// - pulse mode n=1 at fast sources: low half a source period
// - source select picks 4096, 64, 1 or 1/60 Hz
`timescale 1ns/1ps
`default_nettype none
module alarm_watchdog_countdown_timer (
    input  wire logic  ref_clk,
    input  wire logic  nrst,
    input  wire logic  regWrite,
    input  wire logic  regRead,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input  wire logic [7:0] pointerAddr,
    input  wire logic [39:0] clockFields,
    input  wire logic  secondTick,
    input  wire logic  backupMode,
    input  wire logic  powerDown,
    input  wire logic  firstAlarmIrqEnable,
    input  wire logic  alarmInBackupEnable,
    input  wire logic  watchdogIrqEnable,
    output logic       sharedInterruptOut_n,
    output logic       sharedInterruptOe
);
    import rtc_event_pkg::*;

    // clockFields byte order matches alarm bytes: month,date,hour,min,sec
    function automatic logic alarmMatch(input logic [39:0] s, input logic [39:0] c);
        logic [4:0] rpt;
        logic [4:0] need;
        rpt  = {s[39], s[31], s[23], s[15], s[7]};
        case (rpt)
            RPT_MINUTE: need = 5'h01;
            RPT_HOUR:   need = 5'h03;
            RPT_DAY:    need = 5'h07;
            RPT_MONTH:  need = 5'h0f;
            RPT_YEAR:   need = 5'h1f;
            default:    need = 5'h00;
        endcase
        alarmMatch = ((need[0] == 1'b0) || (s[6:0] == c[6:0]))
                  && ((need[1] == 1'b0) || (s[14:8] == c[14:8]))
                  && ((need[2] == 1'b0) || (s[22:16] == c[22:16]))
                  && ((need[3] == 1'b0) || (s[29:24] == c[29:24]))
                  && ((need[4] == 1'b0) || (s[36:32] == c[36:32]));
    endfunction : alarmMatch

    alarm_store_if store ();
    logic tick;
    tick_divider u_div (.ref_clk(ref_clk), .nrst(nrst), .tick(tick));
    alarm_store u_store (.ref_clk(ref_clk), .nrst(nrst), .bus(store.store));

    logic [7:0] watchdogTimeout;
    logic [7:0] countdownValue;
    logic [7:0] countdownReload;
    logic [7:0] countdownControl;
    logic [7:0] alarmConfig;
    logic       firstAlarmFlag;
    logic       secondAlarmFlag;
    logic       watchdogFlag;
    logic       countdownFlag;
    logic       alarmIrq;
    logic       watchdogIrq;
    logic [19:0] wdCount;
    logic [18:0] srcCount;
    logic [18:0] lowCount;
    logic        pulseLow;
    logic        rdFromStore;
    logic [7:0]  localRdata;
    logic        secondSeen;

    // decode
    wire inAlarm1 = regAddr >= ALARM1_BASE_ADDR && regAddr < EVENT_FLAGS_ADDR;
    wire inAlarm2 = regAddr >= ALARM2_BASE_ADDR
                 && regAddr < ALARM2_BASE_ADDR + 8'(ALARM_BYTES);
    wire [7:0] storeOff = inAlarm1 ? regAddr - ALARM1_BASE_ADDR
                                   : regAddr - ALARM2_BASE_ADDR + 8'(ALARM_BYTES);
    assign store.wrEn   = regWrite && (inAlarm1 || inAlarm2);
    assign store.wrIdx  = storeOff[3:0];
    assign store.wrData = regWdata;
    assign store.rdIdx  = storeOff[3:0];
    wire wdWrite    = regWrite && regAddr == WATCHDOG_TIMEOUT_ADDR;
    wire flagsRead  = regRead && regAddr == EVENT_FLAGS_ADDR;
    wire valueWrite = regWrite && regAddr == COUNTDOWN_VALUE_ADDR;
    wire ctrlWrite  = regWrite && regAddr == COUNTDOWN_CONTROL_ADDR;
    wire cfgWrite   = regWrite && regAddr == ALARM_CONFIG_ADDR;

    // alarm evaluation once per second, held off while pointer rests on flags
    wire pointerOnFlags = pointerAddr == EVENT_FLAGS_ADDR;
    wire alarm1Hit = secondSeen && !pointerOnFlags
                  && alarmMatch(store.alarm1, clockFields);
    wire alarm2Hit = secondSeen && !pointerOnFlags && alarmConfig[CFG_ALARM2_EN]
                  && alarmMatch(store.alarm2, clockFields);
    wire alarm1IrqSet = alarm1Hit && firstAlarmIrqEnable
                     && (!backupMode || alarmInBackupEnable);
    // backup-mode interrupt is not released by a read until supply returns
    wire alarmRelease = flagsRead && !backupMode;

    // watchdog
    wire [4:0] wdMult = watchdogTimeout[6:2];
    wire [1:0] wdRes  = watchdogTimeout[1:0];
    wire [15:0] wdUnit = wdRes == 2'b00 ? WD_16TH_TICKS :
                         wdRes == 2'b01 ? WD_4TH_TICKS :
                         wdRes == 2'b10 ? WD_1S_TICKS : WD_4S_TICKS;
    wire [19:0] wdLimit = 20'(wdMult * wdUnit);
    wire wdArmed  = wdMult != 5'h00;
    wire wdExpire = wdArmed && tick && wdCount + 20'h00001 >= wdLimit;

    // countdown timer
    source_sel_t srcSel;
    assign srcSel = source_sel_t'({countdownControl[CTRL_SEL_HI],
                                   countdownControl[CTRL_SEL_LO]});
    wire [18:0] srcPeriod = srcSel == SEL_4096 ? TICKS_4096HZ :
                            srcSel == SEL_64   ? TICKS_64HZ :
                            srcSel == SEL_1    ? TICKS_1HZ : TICKS_60S;
    wire running = countdownControl[CTRL_ENABLE] && countdownReload != 8'h00;
    wire srcTick = running && tick && srcCount + 19'h00001 >= srcPeriod;
    wire reload  = srcTick && countdownValue <= 8'h01;
    wire fastSrc = srcSel == SEL_4096 || srcSel == SEL_64;
    wire [18:0] lowTicks = (countdownReload == 8'h01 && fastSrc)
                         ? (srcPeriod >> 1)
                         : (fastSrc ? srcPeriod : TICKS_64TH);
    wire pulseMode = countdownControl[CTRL_PULSE];
    wire timerIrq  = countdownControl[CTRL_IRQ_EN]
                  && (pulseMode ? pulseLow : countdownFlag);

    // interrupt pin: open drain, driven only while low
    wire anyIrq = alarmIrq || (watchdogIrq && watchdogIrqEnable) || timerIrq;
    assign sharedInterruptOut_n = 1'b0;
    assign sharedInterruptOe    = anyIrq;

    wire [7:0] flagsView = {watchdogFlag, firstAlarmFlag, secondAlarmFlag, 1'b0,
                            countdownFlag, 3'b000};
    wire [7:0] next_localRdata =
        regAddr == WATCHDOG_TIMEOUT_ADDR  ? watchdogTimeout :
        regAddr == EVENT_FLAGS_ADDR       ? flagsView :
        regAddr == COUNTDOWN_VALUE_ADDR   ? countdownValue :
        regAddr == COUNTDOWN_CONTROL_ADDR ? countdownControl :
        regAddr == ALARM_CONFIG_ADDR      ? alarmConfig : 8'h00;
    assign regRdata = rdFromStore ? store.rdData : localRdata;

    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            localRdata  <= 8'h00;
            rdFromStore <= 1'b0;
            secondSeen  <= 1'b0;
        end
        else
        begin
            localRdata  <= next_localRdata;
            rdFromStore <= inAlarm1 || inAlarm2;
            secondSeen  <= secondTick;
        end
    end

    // alarm flags: set wins over the clearing read
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            firstAlarmFlag  <= 1'b0;
            secondAlarmFlag <= 1'b0;
            alarmIrq        <= 1'b0;
            alarmConfig     <= 8'h00;
        end
        else
        begin
            if (cfgWrite)
                alarmConfig <= regWdata;
            firstAlarmFlag  <= alarm1Hit || (firstAlarmFlag && !flagsRead);
            secondAlarmFlag <= alarm2Hit || (secondAlarmFlag && !flagsRead);
            alarmIrq        <= alarm1IrqSet || (alarmIrq && !alarmRelease);
        end
    end

    // watchdog
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            watchdogTimeout <= 8'h00;
            wdCount         <= 20'h00000;
            watchdogFlag    <= 1'b0;
            watchdogIrq     <= 1'b0;
        end
        else
        begin
            if (wdWrite)
            begin
                watchdogTimeout <= regWdata;
                wdCount         <= 20'h00000;
            end
            else if (wdExpire)
                wdCount <= 20'h00000;
            else if (wdArmed && tick)
                wdCount <= wdCount + 20'h00001;
            watchdogFlag <= wdExpire || (watchdogFlag && !flagsRead);
            // a low seven bit write releases; expiry in the same cycle wins
            watchdogIrq <= wdExpire || (watchdogIrq && !wdWrite);
        end
    end

    // countdown timer
    always_ff @(posedge ref_clk)
    begin
        if (!nrst)
        begin
            countdownValue   <= 8'h00;
            countdownReload  <= 8'h00;
            countdownControl <= 8'h00;
            countdownFlag    <= 1'b0;
            srcCount         <= 19'h00000;
            lowCount         <= 19'h00000;
            pulseLow         <= 1'b0;
        end
        else
        begin
            if (valueWrite)
            begin
                countdownReload <= regWdata;
                if (countdownValue == 8'h00)
                    countdownValue <= regWdata;
            end
            else if (srcTick)
                countdownValue <= reload ? countdownReload : countdownValue - 8'h01;
            if (powerDown)
                countdownControl[CTRL_ENABLE] <= 1'b0;
            else if (ctrlWrite)
                countdownControl <= regWdata & CTRL_WRITE_MASK;
            if (srcTick)
                srcCount <= 19'h00000;
            else if (running && tick)
                srcCount <= srcCount + 19'h00001;
            countdownFlag <= reload || (countdownFlag && !flagsRead);
            if (reload)
            begin
                pulseLow <= 1'b1;
                lowCount <= 19'h00000;
            end
            else if (pulseLow && tick)
            begin
                lowCount <= lowCount + 19'h00001;
                if (lowCount + 19'h00001 >= lowTicks)
                    pulseLow <= 1'b0;
            end
        end
    end
endmodule : alarm_watchdog_countdown_timer
`default_nettype wire

// File: alarm_watchdog_countdown_timer_properties.sv
// checker: port-level timing relations of the alarm, watchdog and timer block
// assumes rtc_event_pkg is compiled first and a single reference clock
`timescale 1ns/1ps
`default_nettype none
module alarm_watchdog_countdown_timer_properties (
    input wire logic        ref_clk,
    input wire logic        nrst,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWdata,
    input wire logic [7:0]  regRdata,
    input wire logic [7:0]  pointerAddr,
    input wire logic [39:0] clockFields,
    input wire logic        secondTick,
    input wire logic        backupMode,
    input wire logic        powerDown,
    input wire logic        firstAlarmIrqEnable,
    input wire logic        alarmInBackupEnable,
    input wire logic        watchdogIrqEnable,
    input wire logic        sharedInterruptOut_n,
    input wire logic        sharedInterruptOe
);
    import rtc_event_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!nrst);

    a_pin_tied_low: assert property (sharedInterruptOut_n == 1'b0)
        else $error("interrupt pin data is not low");
    a_reset_quiet: assert property ($rose(nrst) |-> !sharedInterruptOe && regRdata == 8'h00)
        else $error("outputs not cleared by reset");
    a_unmapped_zero: assert property (regAddr > 8'h18 |=> regRdata == 8'h00)
        else $error("unmapped address read not zero");
    a_ctrl_reserved: assert property (regAddr == COUNTDOWN_CONTROL_ADDR |=> regRdata[4:2] == 3'h0)
        else $error("timer control reserved bits not zero");
    a_flags_unused: assert property (regAddr == EVENT_FLAGS_ADDR |=> regRdata[1:0] == 2'h0)
        else $error("flags low bits not zero");
    a_wd_readback: assert property (regWrite && regAddr == WATCHDOG_TIMEOUT_ADDR
        ##1 !regWrite && regAddr == WATCHDOG_TIMEOUT_ADDR
        |=> (regRdata & WATCHDOG_LOW_MASK) == ($past(regWdata, 2) & WATCHDOG_LOW_MASK))
        else $error("watchdog readback differs from write");
    a_wd_holds: assert property (regAddr == WATCHDOG_TIMEOUT_ADDR && !regWrite
        ##1 regAddr == WATCHDOG_TIMEOUT_ADDR |=> $stable(regRdata))
        else $error("watchdog register changed without write");
    a_powerdown_stops: assert property (powerDown && !regWrite
        ##1 regAddr == COUNTDOWN_CONTROL_ADDR && !regWrite |=> !regRdata[CTRL_ENABLE])
        else $error("timer enable survived power-down");
    a_flags_cleared: assert property (regRead && regAddr == EVENT_FLAGS_ADDR
        && !secondTick && !$past(secondTick) && !$past(secondTick, 2)
        ##1 regAddr == EVENT_FLAGS_ADDR
        |=> regRdata[FLAG_ALARM1:FLAG_ALARM2] == 2'h0)
        else $error("alarm flags not cleared by flags read");

    c_flags_read_irq: cover property (regRead && regAddr == EVENT_FLAGS_ADDR && sharedInterruptOe);
    c_power_down: cover property (powerDown);
    c_irq_release: cover property ($fell(sharedInterruptOe));
endmodule : alarm_watchdog_countdown_timer_properties

bind alarm_watchdog_countdown_timer alarm_watchdog_countdown_timer_properties i_props (
    .ref_clk, .nrst, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
    .pointerAddr, .clockFields, .secondTick, .backupMode, .powerDown,
    .firstAlarmIrqEnable, .alarmInBackupEnable, .watchdogIrqEnable,
    .sharedInterruptOut_n, .sharedInterruptOe
);
`default_nettype wire

// File: host_model.sv
// host model: register accesses and the pulled-up interrupt line
// assumes one-cycle strobes taken at the rising edge of ref_clk
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic       ref_clk,
    output var logic        regWrite,
    output var logic        regRead,
    output var logic [7:0]  regAddr,
    output var logic [7:0]  regWdata,
    input  wire logic [7:0] regRdata,
    input  wire logic       sharedInterruptOut_n,
    input  wire logic       sharedInterruptOe,
    output logic            irqPin
);
    import rtc_event_pkg::*;
    // pull-up holds the line high while nobody sinks it
    assign irqPin = sharedInterruptOe ? sharedInterruptOut_n : 1'b1;

    initial
    begin
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = 8'h00;
        regWdata = 8'ha5;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        regWdata <= ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask : rd

    task automatic alarm_off(input logic [7:0] base);
        for (int k = 0; k < ALARM_BYTES; k++)
            wr(base + 8'(k), 8'h00);
    endtask : alarm_off
endmodule : host_model
`default_nettype wire

// File: testbench.sv
// testbench: alarms, watchdog register and countdown timer at the ports
// assumes rtc_event_pkg, the design and host_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import rtc_event_pkg::*;
    // code, differing byte (5 = none), match expected
    localparam logic [8:0] ALARM_CASES [11] = '{9'h1f1, 9'h1e3, 9'h1e0, 9'h1c2, 9'h0c4,
        9'h0c7, 9'h106, 9'h109, 9'h008, 9'h00b, 9'h051};
    localparam logic [39:0] BASE_FIELDS = 40'h0612091530;
    logic        ref_clk, nrst, secondTick, powerDown, firstAlarmIrqEnable;
    logic        backupMode, alarmInBackupEnable;
    logic        regWrite, regRead, sharedInterruptOut_n, sharedInterruptOe, irqPin;
    logic [7:0]  regAddr, regWdata, regRdata, pointerAddr, rdv;
    logic [39:0] clockFields;
    int          errors, n_checks;

    alarm_watchdog_countdown_timer i_alarm_watchdog_countdown_timer (
        .ref_clk, .nrst, .regWrite, .regRead, .regAddr, .regWdata, .regRdata,
        .pointerAddr, .clockFields, .secondTick, .backupMode, .powerDown,
        .firstAlarmIrqEnable, .alarmInBackupEnable, .watchdogIrqEnable(1'b0),
        .sharedInterruptOut_n, .sharedInterruptOe);
    host_model i_host_model (.ref_clk, .regWrite, .regRead, .regAddr, .regWdata,
        .regRdata, .sharedInterruptOut_n, .sharedInterruptOe, .irqPin);

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_pin(input logic exp);
        #1;
        chk({7'h00, irqPin}, {7'h00, exp});
    endtask : chk_pin

    task automatic stop_test;
        if (errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : stop_test

    task automatic tick_second(input logic [39:0] f);
        @(posedge ref_clk);
        clockFields <= f;
        secondTick <= 1'b1;
        @(posedge ref_clk);
        secondTick <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask : tick_second

    task automatic set_alarm(input logic [7:0] a, input logic [4:0] code);
        for (int k = 0; k < ALARM_BYTES; k++)
            i_host_model.wr(a + 8'(k), BASE_FIELDS[8*k +: 8] | {code[k], 7'h00});
    endtask : set_alarm

    task automatic test_reset;
        logic [7:0] addrs [5] = '{8'h09, 8'h0f, 8'h10, 8'h11, 8'h13};
        for (int i = 0; i < 5; i++)
        begin
            i_host_model.rd(addrs[i], rdv);
            chk(rdv, 8'h00);
        end
        chk_pin(1'b1);
    endtask : test_reset

    task automatic test_registers;
        i_host_model.wr(WATCHDOG_TIMEOUT_ADDR, 8'h0e);
        i_host_model.rd(WATCHDOG_TIMEOUT_ADDR, rdv);
        chk(rdv, 8'h0e);
        i_host_model.wr(WATCHDOG_TIMEOUT_ADDR, 8'h00);
        i_host_model.wr(COUNTDOWN_CONTROL_ADDR, 8'hff);
        i_host_model.rd(COUNTDOWN_CONTROL_ADDR, rdv);
        chk(rdv, CTRL_WRITE_MASK);
        i_host_model.rd(COUNTDOWN_VALUE_ADDR, rdv);
        chk(rdv, 8'h00);
        i_host_model.wr(COUNTDOWN_CONTROL_ADDR, 8'h00);
        i_host_model.wr(8'h30, 8'h5a);
        i_host_model.rd(8'h30, rdv);
        chk(rdv, 8'h00);
    endtask : test_registers

    task automatic test_alarms;
        logic [4:0] code;
        logic [2:0] idx;
        logic       hit;
        for (int i = 0; i < 11; i++)
        begin
            {code, idx, hit} = ALARM_CASES[i];
            set_alarm(ALARM1_BASE_ADDR, code);
            tick_second(BASE_FIELDS ^ (40'h1 << (8 * idx)));
            chk_pin(!hit);
            i_host_model.rd(EVENT_FLAGS_ADDR, rdv);
            chk({7'h00, rdv[FLAG_ALARM1]}, {7'h00, hit});
            chk_pin(1'b1);
        end
    endtask : test_alarms

    task automatic test_alarm2;
        @(posedge ref_clk);
        pointerAddr <= EVENT_FLAGS_ADDR;
        set_alarm(ALARM1_BASE_ADDR, 5'h1f);
        tick_second(BASE_FIELDS);
        i_host_model.rd(EVENT_FLAGS_ADDR, rdv);
        chk(rdv, 8'h00);
        @(posedge ref_clk);
        pointerAddr <= 8'h00;
        backupMode <= 1'b1;
        alarmInBackupEnable <= 1'b1;
        tick_second(BASE_FIELDS);
        i_host_model.rd(EVENT_FLAGS_ADDR, rdv);
        chk(rdv, 8'h40);
        chk_pin(1'b0);
        @(posedge ref_clk);
        backupMode <= 1'b0;
        i_host_model.rd(EVENT_FLAGS_ADDR, rdv);
        chk_pin(1'b1);
        i_host_model.alarm_off(ALARM1_BASE_ADDR);
        set_alarm(ALARM2_BASE_ADDR, 5'h1f);
        i_host_model.rd(ALARM2_BASE_ADDR, rdv);
        chk(rdv, 8'hb0);
        tick_second(BASE_FIELDS);
        i_host_model.rd(EVENT_FLAGS_ADDR, rdv);
        chk(rdv, 8'h00);
        i_host_model.wr(ALARM_CONFIG_ADDR, 8'h02);
        tick_second(BASE_FIELDS);
        chk_pin(1'b1);
        i_host_model.rd(EVENT_FLAGS_ADDR, rdv);
        chk(rdv, 8'h20);
    endtask : test_alarm2

    task automatic test_timer;
        i_host_model.wr(COUNTDOWN_VALUE_ADDR, 8'h01);
        i_host_model.wr(COUNTDOWN_CONTROL_ADDR, 8'ha0);
        for (int n = 0; n < 60000 && irqPin !== 1'b0; n++)
            @(posedge ref_clk);
        chk_pin(1'b0);
        if (irqPin !== 1'b0)
            stop_test();
        i_host_model.wr(COUNTDOWN_VALUE_ADDR, 8'h05);
        chk_pin(1'b0);
        i_host_model.rd(COUNTDOWN_VALUE_ADDR, rdv);
        chk(rdv, 8'h01);
        i_host_model.wr(COUNTDOWN_CONTROL_ADDR, 8'h80);
        chk_pin(1'b1);
        i_host_model.wr(COUNTDOWN_CONTROL_ADDR, 8'ha0);
        chk_pin(1'b0);
        i_host_model.rd(EVENT_FLAGS_ADDR, rdv);
        chk(rdv, 8'h08);
        chk_pin(1'b1);
        i_host_model.rd(COUNTDOWN_CONTROL_ADDR, rdv);
        @(posedge ref_clk);
        powerDown <= 1'b1;
        @(posedge ref_clk);
        powerDown <= 1'b0;
        i_host_model.rd(COUNTDOWN_CONTROL_ADDR, rdv);
        chk(rdv, 8'h20);
    endtask : test_timer

    initial
    begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    initial
    begin
        nrst = 1'b0;
        secondTick = 1'b0;
        powerDown = 1'b0;
        backupMode = 1'b0;
        alarmInBackupEnable = 1'b0;
        firstAlarmIrqEnable = 1'b1;
        pointerAddr = 8'h00;
        clockFields = 40'h0;
        errors = 0;
        n_checks = 0;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        test_reset();
        test_registers();
        test_alarms();
        test_alarm2();
        test_timer();
        stop_test();
    end
endmodule : testbench
`default_nettype wire
